// ---- ess_pkg.sv ----
// Register map, fields and carriers for the encoder and switch status block
`default_nettype none
package ess_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_SWITCH_CONFIG   = 8'h34;
    localparam logic [7:0] IDX_RAMP_STATUS     = 8'h35;
    localparam logic [7:0] IDX_ENCODER_CONFIG  = 8'h38;
    localparam logic [7:0] IDX_ENCODER_POS     = 8'h39;
    localparam logic [7:0] IDX_ENCODER_CONST   = 8'h3a;
    localparam logic [7:0] IDX_ENCODER_FLAGS   = 8'h3b;
    localparam logic [7:0] IDX_ENCODER_CAPTURE = 8'h3c;
    localparam logic [7:0] IDX_SLIP_LIMIT      = 8'h3d;

    // Widths, reset values and fraction divisors
    localparam int          ENC_CFG_W         = 11;
    localparam int          SW_CFG_W          = 10;
    localparam int          SLIP_W            = 20;
    localparam logic [31:0] ENC_CONST_RESET   = 32'h0001_0000;
    localparam logic [16:0] DIV_BINARY        = 17'h1_0000;
    localparam logic [16:0] DIV_DECIMAL       = 17'h0_2710;

    // Ramp status bit positions
    localparam int RS_SW_L    = 0;
    localparam int RS_SW_R    = 1;
    localparam int RS_LATCH_L = 2;
    localparam int RS_LATCH_R = 3;
    localparam int RS_STOP_L  = 4;
    localparam int RS_STOP_R  = 5;

    // Encoder flag bit positions
    localparam int EF_INDEX = 0;
    localparam int EF_SLIP  = 1;

    // Index sensitivity encodings
    localparam logic [1:0] SENS_LEVEL  = 2'h0;
    localparam logic [1:0] SENS_ACTIVE = 2'h1;
    localparam logic [1:0] SENS_INACT  = 2'h2;
    localparam logic [1:0] SENS_BOTH   = 2'h3;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Encoder configuration word layout, bit 10 down to bit 0
    typedef struct packed {
        logic       selDecimal;
        logic       latchRamp;
        logic       clearOnIndex;
        logic [1:0] indexSens;
        logic       indexOnce;
        logic       indexCont;
        logic       indexSkipQuadratureMatch;
        logic       polIndex;
        logic       polB;
        logic       polA;
    } ess_enc_cfg_t;

    // Switch configuration word layout, bit 9 down to bit 0
    typedef struct packed {
        logic softStop;
        logic latchRInactive;
        logic latchRActive;
        logic latchLInactive;
        logic latchLActive;
        logic swapLr;
        logic polStopR;
        logic polStopL;
        logic stopREnable;
        logic stopLEnable;
    } ess_sw_cfg_t;

    // Ramp generator view given to this block
    typedef struct packed {
        logic [31:0] actualPosition;
        logic        holdMode;
        logic        moveNegative;
        logic        moveCommand;
        logic        standstill;
    } ess_ramp_t;
endpackage : ess_pkg
`default_nettype wire

// ---- ess_encoder_switch.sv ----
// Encoder counter, index capture, slip check and reference switch status behind AXI4-Lite
//
// Notes on behaviour
// - Left stop flag, bit 4, while left stop
// - Hold mode or away move clears stop
// - Soft stop keeps flag until motor stationary
// - Disabling switch or stop clears flag
// - Stop flags ORed into interrupt output
// - Latch ready flags bits 3,2, write-one clear
// - Bits 1,0 show live switch states
// - Encoder inactive in step-direction mode
// - Signed 32-bit position, read and write, 0x39
// - Fixed-point step constant added per step
// - Decimal bit picks 10^4 or 2^16 divisor
// - Index bit 0, slip bit 1, W1C
// - Slip clear ignored while slip persists
// - Encoder flags ORed into interrupt output
// - Index event captures position into 0x3C
// - Slip when difference exceeds 20-bit limit
// - Zero limit disables the slip check
// - 11-bit read-write encoder config at 0x38
// - Bits 7:6 select index trigger kind
// - Bit 8 selects latch or latch-and-clear
// - Bit 2 sets index input polarity
// - Index needs A/B match unless bit 3
`default_nettype none
module ess_encoder_switch
    import ess_pkg::*;
(
    input  wire logic        clock,         // System clock, 40 MHz
    input  wire logic        reset,         // Asynchronous reset, active high
    // AXI4-Lite slave
    input  wire logic [9:0]  s_axi_awaddr,  // Write address, byte
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [9:0]  s_axi_araddr,  // Read address, byte
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    // Pins
    input  wire logic        encA,          // Encoder channel A
    input  wire logic        encB,          // Encoder channel B
    input  wire logic        encIndex,      // Encoder index channel
    input  wire logic        refLeft,       // Left reference switch
    input  wire logic        refRight,      // Right reference switch
    // Ramp generator side, same clock
    input  wire ess_ramp_t   ramp,          // Ramp position and motion state
    input  wire logic        stepDirMode,   // Step and direction mode active
    output logic             stopLeft,      // Stop request toward left
    output logic             stopRight,     // Stop request toward right
    output logic             interrupt      // Interrupt output, active high
);

    // Byte strobe merge, used by every writable register
    function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = data[8*i +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    // Address decode to register index, shared by read and write paths
    function automatic logic [7:0] regIndex(input logic [9:0] addr);
        return addr[9:2];
    endfunction : regIndex

    function automatic logic isMapped(input logic [9:0] addr);
        logic [7:0] idx;
        idx = addr[9:2];
        return (idx == IDX_SWITCH_CONFIG) || (idx == IDX_RAMP_STATUS) ||
               (idx >= IDX_ENCODER_CONFIG && idx <= IDX_SLIP_LIMIT);
    endfunction : isMapped

    // Two-stage synchronisers for the five pins
    logic [4:0] pinMeta_q;
    logic [4:0] pinSync_q;
    logic [4:0] pinPrev_q;
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pinMeta_q <= 5'h00;
            pinSync_q <= 5'h00;
            pinPrev_q <= 5'h00;
        end else begin
            pinMeta_q <= {refRight, refLeft, encIndex, encB, encA};
            pinSync_q <= pinMeta_q;
            pinPrev_q <= pinSync_q;
        end
    end

    logic aNow, bNow, nNow, aOld, bOld;
    assign aNow = pinSync_q[0];
    assign bNow = pinSync_q[1];
    assign nNow = pinSync_q[2];
    assign aOld = pinPrev_q[0];
    assign bOld = pinPrev_q[1];

    // Registers
    ess_enc_cfg_t      encCfg_q;
    ess_sw_cfg_t       swCfg_q;
    logic [31:0]       encPos_q;
    logic [15:0]       encFrac_q;
    logic [31:0]       encConst_q;
    logic [1:0]        encFlags_q;
    logic [31:0]       encCapture_q;
    logic [SLIP_W-1:0] slipLimit_q;
    logic              onceArmed_q;
    logic              latchL_q, latchR_q;
    logic              stopL_q, stopR_q;
    logic              swLPrev_q, swRPrev_q;
    logic              indexPrev_q;

    // AXI write channel holding
    logic        awHeld_q, wHeld_q;
    logic [9:0]  awAddr_q;
    logic [31:0] wData_q;
    logic [3:0]  wStrb_q;
    logic        wrFire;
    logic [7:0]  wrIdx;
    assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
    assign wrIdx  = regIndex(awAddr_q);

    // Address and data taken in either order
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            awAddr_q      <= 10'h000;
            wData_q       <= 32'h0000_0000;
            wStrb_q       <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready) && !wrFire;
            s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready) && !wrFire;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (wrFire) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Software write decode
    logic wrSwCfg, wrRampSt, wrEncCfg, wrEncPos, wrEncConst, wrEncFlags, wrSlip;
    assign wrSwCfg    = wrFire && wrIdx == IDX_SWITCH_CONFIG;
    assign wrRampSt   = wrFire && wrIdx == IDX_RAMP_STATUS;
    assign wrEncCfg   = wrFire && wrIdx == IDX_ENCODER_CONFIG;
    assign wrEncPos   = wrFire && wrIdx == IDX_ENCODER_POS;
    assign wrEncConst = wrFire && wrIdx == IDX_ENCODER_CONST;
    assign wrEncFlags = wrFire && wrIdx == IDX_ENCODER_FLAGS;
    assign wrSlip     = wrFire && wrIdx == IDX_SLIP_LIMIT;

    logic [31:0] wrMerged;
    assign wrMerged = mergeBytes(32'h0000_0000, wData_q, wStrb_q);

    // Plain configuration registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            encCfg_q    <= '0;
            swCfg_q     <= '0;
            encConst_q  <= ENC_CONST_RESET;
            slipLimit_q <= '0;
        end else begin
            if (wrEncCfg) begin
                encCfg_q <= ess_enc_cfg_t'(ENC_CFG_W'(mergeBytes({21'h0, encCfg_q}, wData_q, wStrb_q)));
            end
            if (wrSwCfg) begin
                swCfg_q <= ess_sw_cfg_t'(SW_CFG_W'(mergeBytes({22'h0, swCfg_q}, wData_q, wStrb_q)));
            end
            if (wrEncConst) begin
                encConst_q <= mergeBytes(encConst_q, wData_q, wStrb_q);
            end
            if (wrSlip) begin
                slipLimit_q <= SLIP_W'(mergeBytes({12'h0, slipLimit_q}, wData_q, wStrb_q));
            end
        end
    end

    // Reference switch levels, after polarity and optional swap
    logic swLAct, swRAct;
    assign swLAct = (swCfg_q.swapLr ? pinSync_q[4] : pinSync_q[3]) ^ swCfg_q.polStopL;
    assign swRAct = (swCfg_q.swapLr ? pinSync_q[3] : pinSync_q[4]) ^ swCfg_q.polStopR;

    // Latch ready flags; new event beats a same-cycle clear
    logic latchLEvt, latchREvt;
    assign latchLEvt = (swCfg_q.latchLActive && swLAct && !swLPrev_q) ||
                       (swCfg_q.latchLInactive && !swLAct && swLPrev_q);
    assign latchREvt = (swCfg_q.latchRActive && swRAct && !swRPrev_q) ||
                       (swCfg_q.latchRInactive && !swRAct && swRPrev_q);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            swLPrev_q <= 1'b0;
            swRPrev_q <= 1'b0;
            latchL_q  <= 1'b0;
            latchR_q  <= 1'b0;
        end else begin
            swLPrev_q <= swLAct;
            swRPrev_q <= swRAct;
            latchL_q  <= latchLEvt || (latchL_q && !(wrRampSt && wrMerged[RS_LATCH_L]));
            latchR_q  <= latchREvt || (latchR_q && !(wrRampSt && wrMerged[RS_LATCH_R]));
        end
    end

    // Stop events: raised while moving into an active enabled switch
    logic relL, relR;
    assign relL = ramp.holdMode || (ramp.moveCommand && !ramp.moveNegative);
    assign relR = ramp.holdMode || (ramp.moveCommand && ramp.moveNegative);
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stopL_q <= 1'b0;
            stopR_q <= 1'b0;
        end else begin
            if (!swCfg_q.stopLEnable) begin
                stopL_q <= 1'b0;
            end else if (swLAct && ramp.moveNegative && !ramp.holdMode) begin
                stopL_q <= 1'b1;
            end else if (relL && (!swCfg_q.softStop || ramp.standstill)) begin
                stopL_q <= 1'b0;
            end
            if (!swCfg_q.stopREnable) begin
                stopR_q <= 1'b0;
            end else if (swRAct && !ramp.moveNegative && !ramp.holdMode) begin
                stopR_q <= 1'b1;
            end else if (relR && (!swCfg_q.softStop || ramp.standstill)) begin
                stopR_q <= 1'b0;
            end
        end
    end

    // Quadrature decode; a double step is illegal and ignored
    logic stepDown, encOn, stepAny, dirUp;
    assign encOn    = !stepDirMode;
    assign stepAny  = encOn && ((aNow ^ aOld) ^ (bNow ^ bOld));
    assign dirUp    = aOld ^ bNow;
    assign stepDown = stepAny && !dirUp;

    // Index detection: polarity, A/B match, sensitivity
    logic idxLevel, idxTrig, idxEvent;
    assign idxLevel = (nNow == encCfg_q.polIndex) &&
                      (encCfg_q.indexSkipQuadratureMatch ||
                       (aNow == encCfg_q.polA && bNow == encCfg_q.polB));
    always_comb begin
        case (encCfg_q.indexSens)
            SENS_LEVEL:  idxTrig = idxLevel;
            SENS_ACTIVE: idxTrig = idxLevel && !indexPrev_q;
            SENS_INACT:  idxTrig = !idxLevel && indexPrev_q;
            SENS_BOTH:   idxTrig = idxLevel != indexPrev_q;
            default:     idxTrig = 1'b0;
        endcase
    end
    assign idxEvent = encOn && idxTrig && (encCfg_q.indexCont || onceArmed_q);

    // Fractional step arithmetic; decimal mode wraps the fraction at 10^4
    logic [16:0] divisor;
    logic [16:0] fracSum, fracDiff;
    logic        carry, borrow;
    logic [31:0] stepInt;
    logic [31:0] posNext;
    logic [15:0] fracNext;
    assign divisor  = encCfg_q.selDecimal ? DIV_DECIMAL : DIV_BINARY;
    assign stepInt  = {{16{encConst_q[31]}}, encConst_q[31:16]};
    assign fracSum  = {1'b0, encFrac_q} + {1'b0, encConst_q[15:0]};
    assign carry    = fracSum >= divisor;
    assign fracDiff = {1'b0, encFrac_q} - {1'b0, encConst_q[15:0]};
    assign borrow   = fracDiff[16];
    always_comb begin
        posNext  = encPos_q;
        fracNext = encFrac_q;
        if (stepAny && dirUp) begin
            posNext  = encPos_q + stepInt + {31'h0, carry};
            fracNext = carry ? 16'(fracSum - divisor) : fracSum[15:0];
        end else if (stepDown) begin
            posNext  = encPos_q - stepInt - {31'h0, borrow};
            fracNext = borrow ? 16'(fracDiff + divisor) : fracDiff[15:0];
        end
    end

    // Position counter, capture and one-shot arming
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            encPos_q     <= 32'h0000_0000;
            encFrac_q    <= 16'h0000;
            encCapture_q <= 32'h0000_0000;
            onceArmed_q  <= 1'b0;
            indexPrev_q  <= 1'b0;
        end else begin
            indexPrev_q <= idxLevel;
            if (wrEncPos) begin
                encPos_q  <= mergeBytes(encPos_q, wData_q, wStrb_q);
                encFrac_q <= 16'h0000;
            end else if (idxEvent && encCfg_q.clearOnIndex) begin
                encPos_q  <= 32'h0000_0000;
                encFrac_q <= 16'h0000;
            end else begin
                encPos_q  <= posNext;
                encFrac_q <= fracNext;
            end
            if (idxEvent) begin
                encCapture_q <= encPos_q;
            end
            if (wrEncCfg) begin
                onceArmed_q <= wData_q[5] && wStrb_q[0];
            end else if (idxEvent) begin
                onceArmed_q <= 1'b0;
            end
        end
    end

    // Slip check against the ramp position
    logic [31:0] posDiff, posAbs;
    logic        slipNow;
    assign posDiff = encPos_q - ramp.actualPosition;
    assign posAbs  = posDiff[31] ? 32'(-posDiff) : posDiff;
    assign slipNow = encOn && (slipLimit_q != '0) && (posAbs > {12'h0, slipLimit_q});

    // Encoder flags; set wins over clear, slip clear refused while slip persists
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            encFlags_q <= 2'h0;
        end else begin
            encFlags_q[EF_INDEX] <= idxEvent ||
                (encFlags_q[EF_INDEX] && !(wrEncFlags && wrMerged[EF_INDEX]));
            encFlags_q[EF_SLIP]  <= slipNow ||
                (encFlags_q[EF_SLIP] && !(wrEncFlags && wrMerged[EF_SLIP]));
        end
    end

    // Interrupt and stop outputs, registered
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            interrupt <= 1'b0;
            stopLeft  <= 1'b0;
            stopRight <= 1'b0;
        end else begin
            interrupt <= stopL_q || stopR_q || (|encFlags_q);
            stopLeft  <= stopL_q;
            stopRight <= stopR_q;
        end
    end

    // Read path: one read at a time, data one cycle after the address is taken
    logic [31:0] rdValue;
    always_comb begin
        case (regIndex(s_axi_araddr))
            IDX_SWITCH_CONFIG:   rdValue = {22'h0, swCfg_q};
            IDX_RAMP_STATUS:     rdValue = {26'h0, stopR_q, stopL_q, latchR_q, latchL_q, swRAct, swLAct};
            IDX_ENCODER_CONFIG:  rdValue = {21'h0, encCfg_q};
            IDX_ENCODER_POS:     rdValue = encPos_q;
            IDX_ENCODER_FLAGS:   rdValue = {30'h0, encFlags_q};
            IDX_ENCODER_CAPTURE: rdValue = encCapture_q;
            default:             rdValue = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdValue;
                s_axi_rresp  <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : ess_encoder_switch
`default_nettype wire

// ---- ess_checker.sv ----
// Assertion checker for the encoder and switch status block
`default_nettype none
module ess_checker
    import ess_pkg::*;
(
    input wire logic        clock, reset, // Clock, async reset
    input wire logic        s_axi_awvalid, s_axi_awready, // Write address
    input wire logic        s_axi_wvalid, s_axi_wready, // Write data
    input wire logic        s_axi_bvalid, s_axi_bready, // Write response
    input wire logic        s_axi_arvalid, s_axi_arready, // Read address
    input wire logic        s_axi_rvalid, s_axi_rready, // Read data
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire ess_ramp_t   ramp, // Ramp state
    input wire logic        stopLeft, stopRight, interrupt // Status outputs
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    // Bus answers stand until taken
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata unstable");
    a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("write answer late");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    // Stop flags feed the interrupt, hold clears them
    a_stop_int_l: assert property (stopLeft |-> interrupt)
        else $error("left stop no interrupt");
    a_stop_int_r: assert property (stopRight |-> interrupt)
        else $error("right stop no interrupt");
    a_hold_clears_l: assert property ((ramp.holdMode && ramp.standstill) [*3] |-> !stopLeft)
        else $error("left stop in hold");
    a_hold_clears_r: assert property ((ramp.holdMode && ramp.standstill) [*3] |-> !stopRight)
        else $error("right stop in hold");
    c_stop: cover property (stopLeft);
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_int_clear: cover property ($fell(interrupt));
endmodule : ess_checker
`default_nettype wire

// ---- ess_enc_model.sv ----
// Quadrature encoder with index channel, stepped by the bench
`default_nettype none
module ess_enc_model (
    input  wire logic clock,    // Bench clock
    input  wire logic stepUp,   // One step forward
    input  wire logic stepDn,   // One step backward
    input  wire logic idxOn,    // Index level request
    output logic      encA,     // Channel A
    output logic      encB,     // Channel B
    output logic      encIndex  // Index channel, high active
);
    logic [1:0] ph_q = 2'h0;
    // Gray phase, one channel changes per step so no step is ambiguous
    always_ff @(posedge clock) begin
        if (stepUp) ph_q <= ph_q + 2'h1;
        else if (stepDn) ph_q <= ph_q - 2'h1;
    end
    assign encA     = ph_q[1];
    assign encB     = ph_q[1] ^ ph_q[0];
    assign encIndex = idxOn;
endmodule : ess_enc_model
`default_nettype wire

// ---- ess_encoder_switch_tb.sv ----
// Self-checking testbench for the encoder and switch status block
`default_nettype none
module ess_encoder_switch_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ess_pkg::*;
    typedef struct packed { logic w; logic [7:0] i; logic [31:0] d, e; logic [1:0] r; } ess_row_t;
    logic        clock = 1'h0, reset = 1'h1, stepUp = 1'h0, stepDn = 1'h0, idxOn = 1'h0;
    logic [9:0]  s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic        s_axi_rready = 1'h0, refLeft = 1'h0, refRight = 1'h0, stepDirMode = 1'h0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        encA, encB, encIndex, stopLeft, stopRight, interrupt;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    ess_ramp_t   ramp = '0;
    int          mismatches = 0, num_checks = 0;
    ess_row_t    rows [7] = '{
        '{1'h0, IDX_ENCODER_POS, 32'h0, 32'h0, RESP_OKAY},
        '{1'h0, IDX_RAMP_STATUS, 32'h0, 32'h0, RESP_OKAY},
        '{1'h1, IDX_ENCODER_CONFIG, 32'hffff_ffdf, 32'h0000_07df, RESP_OKAY},
        '{1'h1, IDX_ENCODER_POS, 32'h8000_0001, 32'h8000_0001, RESP_OKAY},
        '{1'h1, IDX_ENCODER_CONST, 32'h0001_2345, 32'h0, RESP_OKAY},
        '{1'h1, IDX_SLIP_LIMIT, 32'hfff0_0000, 32'h0, RESP_OKAY},
        '{1'h1, 8'h3e, 32'h1, 32'h0, RESP_SLVERR}};
    ess_encoder_switch u_dut (.*);
    ess_enc_model u_enc (.*);
    // Free-running 40 MHz clock
    initial forever #12.5 clock = ~clock;
    task automatic end_sim;
        if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("BAD %0t got %h want %h", $time, s, e);
        end
    endtask : chk
    // Bounded wait, a stuck handshake ends the run
    task automatic tick(inout int n);
        @(posedge clock);
        n++;
        if (n > 100) begin
            mismatches++;
            end_sim();
        end
    endtask : tick
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        int n = 0;
        bit a = 1'b1, w = 1'b1;
        @(posedge clock);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (a || w) begin
            tick(n);
            a = a && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= a;
            s_axi_wvalid <= w;
        end
        do tick(n); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] i);
        int n = 0;
        @(posedge clock);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do tick(n); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do tick(n); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask : rd
    task automatic rc(input logic [7:0] i, input logic [31:0] e);
        rd(i);
        chk(rv, e);
    endtask : rc
    // One step, then room for the synchroniser
    task automatic steps(input int k, input logic u);
        repeat (k) begin
            stepUp <= u;
            stepDn <= !u;
            @(posedge clock);
            stepUp <= 1'h0;
            stepDn <= 1'h0;
            repeat (4) @(posedge clock);
        end
    endtask : steps
    // Table rows, then hand-written cases
    initial begin
        repeat (4) @(posedge clock);
        reset <= 1'h0;
        foreach (rows[k]) begin
            if (rows[k].w) begin
                wr(rows[k].i, rows[k].d);
                chk({30'h0, rsp}, {30'h0, rows[k].r});
            end
            rc(rows[k].i, rows[k].e);
            chk({30'h0, rsp}, {30'h0, rows[k].r});
        end
        wr(IDX_ENCODER_CONFIG, 32'h0);
        wr(IDX_ENCODER_CONST, 32'h0002_0000);
        wr(IDX_ENCODER_POS, 32'h0);
        steps(3, 1'h1);
        steps(1, 1'h0);
        rc(IDX_ENCODER_POS, 32'h4);
        wr(IDX_ENCODER_CONFIG, 32'h400);
        wr(IDX_ENCODER_CONST, 32'h1388);
        wr(IDX_ENCODER_POS, 32'h0);
        steps(2, 1'h1);
        rc(IDX_ENCODER_POS, 32'h1);
        stepDirMode <= 1'h1;
        steps(2, 1'h1);
        rc(IDX_ENCODER_POS, 32'h1);
        stepDirMode <= 1'h0;
        wr(IDX_ENCODER_CONFIG, 32'h15c);
        wr(IDX_ENCODER_POS, 32'h1234);
        idxOn <= 1'h1;
        repeat (6) @(posedge clock);
        idxOn <= 1'h0;
        rc(IDX_ENCODER_CAPTURE, 32'h1234);
        rc(IDX_ENCODER_POS, 32'h0);
        rc(IDX_ENCODER_FLAGS, 32'h1);
        chk({31'h0, interrupt}, 32'h1);
        wr(IDX_ENCODER_FLAGS, 32'h1);
        rc(IDX_ENCODER_FLAGS, 32'h0);
        chk({31'h0, interrupt}, 32'h0);
        wr(IDX_SLIP_LIMIT, 32'h3);
        wr(IDX_ENCODER_POS, 32'h3);
        rc(IDX_ENCODER_FLAGS, 32'h0);
        wr(IDX_ENCODER_POS, 32'h4);
        rc(IDX_ENCODER_FLAGS, 32'h2);
        wr(IDX_ENCODER_FLAGS, 32'h2);
        rc(IDX_ENCODER_FLAGS, 32'h2);
        wr(IDX_SLIP_LIMIT, 32'h0);
        wr(IDX_ENCODER_FLAGS, 32'h2);
        rc(IDX_ENCODER_FLAGS, 32'h0);
        ramp <= '{32'h0, 1'h0, 1'h1, 1'h1, 1'h0};
        refLeft <= 1'h1;
        wr(IDX_SWITCH_CONFIG, 32'h1);
        rc(IDX_RAMP_STATUS, 32'h11);
        chk({31'h0, stopLeft & interrupt}, 32'h1);
        wr(IDX_SWITCH_CONFIG, 32'h0);
        rc(IDX_RAMP_STATUS, 32'h1);
        wr(IDX_SWITCH_CONFIG, 32'h1);
        ramp.holdMode <= 1'h1;
        ramp.standstill <= 1'h1;
        rc(IDX_RAMP_STATUS, 32'h1);
        wr(IDX_SWITCH_CONFIG, 32'h20);
        refLeft <= 1'h0;
        repeat (4) @(posedge clock);
        refLeft <= 1'h1;
        refRight <= 1'h1;
        repeat (4) @(posedge clock);
        rc(IDX_RAMP_STATUS, 32'h7);
        wr(IDX_RAMP_STATUS, 32'h4);
        rc(IDX_RAMP_STATUS, 32'h3);
        ramp <= '{32'h0, 1'h0, 1'h0, 1'h1, 1'h0};
        wr(IDX_SWITCH_CONFIG, 32'h2);
        rc(IDX_RAMP_STATUS, 32'h23);
        end_sim();
    end
endmodule : ess_encoder_switch_tb
bind ess_encoder_switch ess_checker u_chk (.*);
`default_nettype wire
